/* src/ppl_port.sv */
// one parallel port: latches, direction, drain select, sampling, drivers
`timescale 1ns/100ps
module ppl_port #(
  parameter int W        = 8,
  parameter bit HAS_DIR  = 1'b1,
  parameter bit HAS_OD   = 1'b0
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  input  wire logic                   stateTick,
  input  wire logic                   sel,
  input  wire ppl_pkg::ppl_req_t      req,
  input  wire ppl_pkg::ppl_alt_t      alt,
  input  wire logic [ppl_pkg::MAXW-1:0] pinIn,
  output logic      [ppl_pkg::MAXW-1:0] pinOut,
  output logic      [ppl_pkg::MAXW-1:0] pinOe,
  output logic      [ppl_pkg::MAXW-1:0] altIn,
  output logic      [ppl_pkg::MAXW-1:0] view
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [W-1:0] sync1_q, sync2_q, sync3_q, level_q, inLatch_q;
  logic [W-1:0] latch_q, dir_q, drain_q;
  logic [W-1:0] effDir, drvVal, readVal, src, mask, result;
  logic         isWrite, isRmw;

  // three stage pin synchroniser
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (ce) begin
      sync1_q <= pinIn[W-1:0];
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // level accepted once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      level_q <= '0;
    end else if (ce) begin
      for (int i = 0; i < W; i++) begin
        if (sync2_q[i] == sync3_q[i]) level_q[i] <= sync3_q[i];
      end
    end
  end

  // input latch loads every state time regardless of direction
  always_ff @(posedge clk) begin
    if (reset) begin
      inLatch_q <= '0;
    end else if (ce && stateTick) begin
      inLatch_q <= level_q;
    end
  end

  // ----------------------------------------------------------------
  // software access
  // ----------------------------------------------------------------
  // effective direction: hardware owned lines follow the alternate unit
  assign effDir = HAS_DIR ? ((alt.autoDir[W-1:0] & alt.autoOut[W-1:0]) |
                             (~alt.autoDir[W-1:0] & dir_q)) : '0;

  // per line read source: output latch where the direction register is set, sampled pin otherwise
  assign readVal = (dir_q & latch_q) | (~dir_q & inLatch_q);

  // source of the selected register
  always_comb begin
    unique case (req.target)
      ppl_pkg::TGT_DATA:      src = readVal;
      ppl_pkg::TGT_DIRECTION: src = dir_q;
      ppl_pkg::TGT_DRAIN:     src = drain_q;
      default:                src = '0;
    endcase
  end

  assign mask    = req.mask[W-1:0];
  assign isWrite = sel && (req.op == ppl_pkg::OP_WRITE);
  assign isRmw   = sel && (req.op == ppl_pkg::OP_RMW_SET || req.op == ppl_pkg::OP_RMW_CLEAR ||
                           req.op == ppl_pkg::OP_RMW_TOGGLE);

  // bit set, clear and toggle on masked lines only
  always_comb begin
    unique case (req.op)
      ppl_pkg::OP_RMW_SET:    result = src | mask;
      ppl_pkg::OP_RMW_CLEAR:  result = src & ~mask;
      ppl_pkg::OP_RMW_TOGGLE: result = src ^ mask;
      ppl_pkg::OP_WRITE:      result = (src & ~mask) | (req.data[W-1:0] & mask);
      default:                result = src;
    endcase
  end

  // output latch: writes land here whatever the direction
  always_ff @(posedge clk) begin
    if (reset) begin
      latch_q <= ppl_pkg::RST_LATCH[W-1:0];
    end else if (ce && (isWrite || isRmw) && req.target == ppl_pkg::TGT_DATA) begin
      if (isWrite) latch_q <= (latch_q & ~mask) | (req.data[W-1:0] & mask);
      else         latch_q <= result;
    end
  end

  // direction register
  always_ff @(posedge clk) begin
    if (reset) begin
      dir_q <= ppl_pkg::RST_DIRECTION[W-1:0];
    end else if (ce && HAS_DIR && (isWrite || isRmw) && req.target == ppl_pkg::TGT_DIRECTION) begin
      dir_q <= result;
    end
  end

  // drain select register
  always_ff @(posedge clk) begin
    if (reset) begin
      drain_q <= ppl_pkg::RST_DRAIN[W-1:0];
    end else if (ce && HAS_OD && (isWrite || isRmw) && req.target == ppl_pkg::TGT_DRAIN) begin
      drain_q <= result;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // latch gated by the alternate output data
  assign drvVal = latch_q & ((alt.outEn[W-1:0] & alt.outData[W-1:0]) |
                             ~alt.outEn[W-1:0]);

  // driver registers; open drain never drives high
  always_ff @(posedge clk) begin
    if (reset) begin
      pinOut <= '0;
      pinOe  <= '0;
    end else if (ce) begin
      pinOut <= ppl_pkg::MAXW'(drvVal & ~drain_q);
      pinOe  <= ppl_pkg::MAXW'(effDir & ~(drain_q & drvVal));
    end
  end

  // alternate input follows the sampled pin level
  always_ff @(posedge clk) begin
    if (reset) begin
      altIn <= '0;
    end else if (ce) begin
      altIn <= ppl_pkg::MAXW'(level_q);
    end
  end

  // readback view, upper unused lines read zero
  assign view = ppl_pkg::MAXW'(src);

endmodule : ppl_port

/* src/ppl_pkg.sv */
// shared constants and types of the parallel port line logic
package ppl_pkg;

  // ----------------------------------------------------------------
  // port map
  // ----------------------------------------------------------------
  localparam int NPORT   = 9;   // p0l p0h p1l p1h p2 p3 p4 p5 p6
  localparam int MAXW    = 16;  // widest line vector carried
  localparam int PORT_IX_WIDTH = 4;
  localparam logic [PORT_IX_WIDTH-1:0] PIX_P0L = 4'h0;
  localparam logic [PORT_IX_WIDTH-1:0] PIX_P0H = 4'h1;
  localparam logic [PORT_IX_WIDTH-1:0] PIX_P1L = 4'h2;
  localparam logic [PORT_IX_WIDTH-1:0] PIX_P1H = 4'h3;
  localparam logic [PORT_IX_WIDTH-1:0] PIX_P2  = 4'h4;
  localparam logic [PORT_IX_WIDTH-1:0] PIX_P3  = 4'h5;
  localparam logic [PORT_IX_WIDTH-1:0] PIX_P4  = 4'h6;
  localparam logic [PORT_IX_WIDTH-1:0] PIX_P5  = 4'h7;
  localparam logic [PORT_IX_WIDTH-1:0] PIX_P6  = 4'h8;

  // line counts
  localparam int BYTE_LINES = 8;
  localparam int P3_LINES   = 15;
  localparam int P5_LINES   = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [MAXW-1:0] RST_DIRECTION = 16'h0000;  // all inputs
  localparam logic [MAXW-1:0] RST_DRAIN     = 16'h0000;  // push/pull
  localparam logic [MAXW-1:0] RST_LATCH     = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int STATE_TIME_NS   = 20;
  localparam int STATE_CYCLES    = (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATE_CNT_W     = 4;

  // ----------------------------------------------------------------
  // access request
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TGT_DATA,
    TGT_DIRECTION,
    TGT_DRAIN
  } ppl_target_t;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_RMW_SET,
    OP_RMW_CLEAR,
    OP_RMW_TOGGLE
  } ppl_op_t;

  typedef struct packed {
    logic [PORT_IX_WIDTH-1:0] port;
    ppl_target_t              target;
    ppl_op_t                  op;
    logic [MAXW-1:0]          data;
    logic [MAXW-1:0]          mask;
  } ppl_req_t;

  // alternate function controls, one bit per line
  typedef struct packed {
    logic [MAXW-1:0] outEn;    // alternate output function enabled
    logic [MAXW-1:0] outData;  // alternate output data
    logic [MAXW-1:0] autoDir;  // hardware owns the direction
    logic [MAXW-1:0] autoOut;  // hardware direction value, 1 = drive
  } ppl_alt_t;

  // line count of each port
  function automatic int portWidth(input int ix);
    case (ix)
      5:       portWidth = P3_LINES;
      7:       portWidth = P5_LINES;
      default: portWidth = BYTE_LINES;
    endcase
  endfunction : portWidth

  // open drain select exists on p2, p3 and p6 only
  function automatic bit portHasDrain(input int ix);
    portHasDrain = (ix == 4) || (ix == 5) || (ix == 8);
  endfunction : portHasDrain

  // p5 has no direction control
  function automatic bit portHasDir(input int ix);
    portHasDir = (ix != 7);
  endfunction : portHasDir

endpackage : ppl_pkg

/* src/parallel_port_line_logic.sv */
// top of the parallel port line logic: state timer, request routing, readback
`timescale 1ns/100ps

// ------------------------------------------------------------------
// top
// ------------------------------------------------------------------
module parallel_port_line_logic (
  input  wire logic                                    clk,
  input  wire logic                                    reset,
  input  wire logic                                    ce,
  input  wire logic                                    reqValid,
  input  wire ppl_pkg::ppl_req_t                       req,
  input  wire ppl_pkg::ppl_alt_t                       alt    [ppl_pkg::NPORT],
  input  wire logic [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] pinIn,
  output logic      [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] pinOut,
  output logic      [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] pinOe,
  output logic      [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] altIn,
  output logic      [ppl_pkg::MAXW-1:0]                rdData_q,
  output logic                                         rdValid_q,
  output logic                                         stateTick_q
);

  // ----------------------------------------------------------------
  // state time
  // ----------------------------------------------------------------
  logic [ppl_pkg::STATE_CNT_W-1:0] stateCnt_q;

  // divides the clock down to one tick per state time
  always_ff @(posedge clk) begin
    if (reset) begin
      stateCnt_q  <= '0;
      stateTick_q <= 1'b0;
    end else if (ce) begin
      if (stateCnt_q == ppl_pkg::STATE_CNT_W'(ppl_pkg::STATE_CYCLES - 1)) begin
        stateCnt_q  <= '0;
        stateTick_q <= 1'b1;
      end else begin
        stateCnt_q  <= stateCnt_q + 1'b1;
        stateTick_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // ports
  // ----------------------------------------------------------------
  logic [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] view;
  logic                                        portValid;

  assign portValid = (req.port < ppl_pkg::PORT_IX_WIDTH'(ppl_pkg::NPORT));

  // one instance per port, widths and options from the port map
  for (genvar p = 0; p < ppl_pkg::NPORT; p++) begin : g_port
    ppl_port #(
      .W       (ppl_pkg::portWidth(p)),
      .HAS_DIR (ppl_pkg::portHasDir(p)),
      .HAS_OD  (ppl_pkg::portHasDrain(p))
    ) u_port (
      .clk       (clk),
      .reset     (reset),
      .ce        (ce),
      .stateTick (stateTick_q),
      .sel       (reqValid && req.port == ppl_pkg::PORT_IX_WIDTH'(p)),
      .req       (req),
      .alt       (alt[p]),
      .pinIn     (pinIn[p]),
      .pinOut    (pinOut[p]),
      .pinOe     (pinOe[p]),
      .altIn     (altIn[p]),
      .view      (view[p])
    );
  end

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  // every request taken while ce is high answers next cycle with the pre-access value
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_q  <= '0;
      rdValid_q <= 1'b0;
    end else if (ce) begin
      rdValid_q <= reqValid;
      if (reqValid) begin
        rdData_q <= portValid ? view[req.port] : '0;
      end
    end
  end

endmodule : parallel_port_line_logic

/* dv/ppl_pins.sv */
// far-side pin model: external drivers and pull-ups on every line
`timescale 1ns/100ps
module ppl_pins (
  input  wire logic [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] pinOut,
  input  wire logic [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] pinOe,
  input  wire logic [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] extEn,
  input  wire logic [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] extVal,
  output logic      [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] pinIn
);
  // wire level: device driver, else external driver, else pull-up high
  always_comb begin
    pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal) | (~pinOe & ~extEn);
  end
endmodule : ppl_pins

/* dv/ppl_chk.sv */
// concurrent checks on the top ports of the parallel port line logic
`timescale 1ns/100ps
module ppl_chk (
  input wire logic                                         clk,
  input wire logic                                         reset,
  input wire logic                                         ce,
  input wire logic                                         reqValid,
  input wire ppl_pkg::ppl_req_t                            req,
  input wire logic [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] pinIn,
  input wire logic [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] pinOe,
  input wire logic [ppl_pkg::NPORT-1:0][ppl_pkg::MAXW-1:0] altIn,
  input wire logic [ppl_pkg::MAXW-1:0]                     rdData_q,
  input wire logic                                         rdValid_q,
  input wire logic                                         stateTick_q
);
  logic [3:0] sinceRst_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // cycles since reset release, saturating
  always_ff @(posedge clk) begin
    if (reset) sinceRst_q <= 4'h0;
    else if (sinceRst_q != 4'hf) sinceRst_q <= sinceRst_q + 4'h1;
  end
  sequence s_take; reqValid && ce; endsequence
  sequence s_tickPair; !stateTick_q ##1 stateTick_q; endsequence
  sequence s_tickRun; (stateTick_q && ce) ##1 ce; endsequence
  property p_answer; s_take |=> rdValid_q; endproperty
  a_answer: assert property (p_answer) else $error("read answer missing");
  property p_quiet; ce && !reqValid |=> !rdValid_q; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_tick; s_tickRun |-> s_tickPair; endproperty
  a_tick: assert property (p_tick) else $error("state time period wrong");
  property p_relFall; $fell(reset) |-> pinOe == '0 && altIn == '0; endproperty
  a_relFall: assert property (p_relFall) else $error("lines driven after reset");
  property p_p5oe; pinOe[ppl_pkg::PIX_P5] == '0; endproperty
  a_p5oe: assert property (p_p5oe) else $error("input only port driven");
  property p_width; pinOe[ppl_pkg::PIX_P3][15] == 1'b0 && pinOe[0][15:8] == 8'h00; endproperty
  a_width: assert property (p_width) else $error("line beyond port width");
  property p_p5dir;
    s_take ##0 (req.port == ppl_pkg::PIX_P5 && req.target == ppl_pkg::TGT_DIRECTION)
      |=> rdData_q == 16'h0000;
  endproperty
  a_p5dir: assert property (p_p5dir) else $error("direction on input port");
  property p_noDrain;
    s_take ##0 (req.port == ppl_pkg::PIX_P4 && req.target == ppl_pkg::TGT_DRAIN)
      |=> rdData_q == 16'h0000;
  endproperty
  a_noDrain: assert property (p_noDrain) else $error("drain select on port 4");
  property p_altIn;
    (ce && $stable(pinIn[4][7:0]) && sinceRst_q == 4'hf)[*8]
      |-> altIn[4][7:0] == pinIn[4][7:0];
  endproperty
  a_altIn: assert property (p_altIn) else $error("alternate input stale");
endmodule : ppl_chk
bind parallel_port_line_logic ppl_chk u_chk (.clk(clk), .reset(reset), .ce(ce),
  .reqValid(reqValid), .req(req), .pinIn(pinIn), .pinOe(pinOe), .altIn(altIn),
  .rdData_q(rdData_q), .rdValid_q(rdValid_q), .stateTick_q(stateTick_q));

/* dv/testbench.sv */
// self-checking bench of the parallel port line logic
`timescale 1ns/100ps
module testbench;
  localparam ppl_pkg::ppl_op_t     RD = ppl_pkg::OP_READ;
  localparam ppl_pkg::ppl_op_t     WR = ppl_pkg::OP_WRITE;
  localparam ppl_pkg::ppl_target_t DAT = ppl_pkg::TGT_DATA;
  localparam ppl_pkg::ppl_target_t DIR = ppl_pkg::TGT_DIRECTION;
  localparam ppl_pkg::ppl_target_t ODR = ppl_pkg::TGT_DRAIN;
  logic                     clk = 1'b0;
  logic                     reset = 1'b1;
  logic                     reqValid = 1'b0;
  logic                     ce = 1'b1;
  ppl_pkg::ppl_req_t        req = '0;
  ppl_pkg::ppl_alt_t        alt [ppl_pkg::NPORT];
  logic [8:0][15:0]         pinIn, pinOut, pinOe, altIn, extEn, extVal;
  logic [15:0]              rdData_q, rd;
  logic                     rdValid_q, stateTick_q;
  int                       error_cnt = 0;
  int                       tests_run = 0;
  // free-running clock
  always #5 clk = ~clk;
  parallel_port_line_logic dut (.clk(clk), .reset(reset), .ce(ce), .reqValid(reqValid),
    .req(req), .alt(alt), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .altIn(altIn),
    .rdData_q(rdData_q), .rdValid_q(rdValid_q), .stateTick_q(stateTick_q));
  ppl_pins u_pins (.pinOut(pinOut), .pinOe(pinOe), .extEn(extEn), .extVal(extVal),
    .pinIn(pinIn));
  // compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one request, answer kept in rd
  task automatic acc(input logic [3:0] port, input ppl_pkg::ppl_target_t tg,
                     input ppl_pkg::ppl_op_t op, input logic [15:0] d, input logic [15:0] m);
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{port, tg, op, d, m};
    @(posedge clk);
    reqValid <= 1'b0;
    #1;
    chk("answer strobe", {15'h0, rdValid_q}, 16'h0001);
    rd = rdData_q;
  endtask : acc
  task automatic rdchk(input logic [3:0] port, input ppl_pkg::ppl_target_t tg,
                       input logic [15:0] exp, input string what);
    acc(port, tg, RD, 16'h0000, 16'hffff);
    chk(what, rd, exp);
  endtask : rdchk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // watchdog
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  // main sequence
  initial begin
    for (int p = 0; p < 9; p++) alt[p] = '0;
    extEn = '0;
    extVal = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    idle(2);
    for (int p = 0; p < 9; p++) rdchk(p[3:0], DIR, 16'h0000, "reset direction");
    rdchk(4'h4, ODR, 16'h0000, "reset drain");
    // input line: write lands in latch, read gives sampled pin
    extEn[6] <= 16'h00ff;
    extVal[6] <= 16'h005a;
    acc(4'h6, DAT, WR, 16'h000f, 16'h00ff);
    idle(10);
    rdchk(4'h6, DAT, 16'h005a, "input read");
    chk("input floats", pinOe[6], 16'h0000);
    acc(4'h6, DAT, ppl_pkg::OP_RMW_SET, 16'h0000, 16'h0001);
    acc(4'h6, DIR, WR, 16'h00ff, 16'h00ff);
    extEn[6] <= 16'h0000;
    idle(4);
    rdchk(4'h6, DAT, 16'h005b, "latch from pin");
    chk("output value", pinOut[6], 16'h005b);
    chk("output enable", pinOe[6], 16'h00ff);
    acc(4'h6, DAT, ppl_pkg::OP_RMW_TOGGLE, 16'h0000, 16'h00f0);
    acc(4'h6, DAT, ppl_pkg::OP_RMW_CLEAR, 16'h0000, 16'h0008);
    idle(10);
    rdchk(4'h6, DAT, 16'h00a3, "latch after rmw");
    chk("pin after rmw", pinOut[6], 16'h00a3);
    chk("alt input", altIn[6], 16'h00a3);
    alt[6].outEn <= 16'h00ff;
    alt[6].outData <= 16'h000f;
    alt[0].outEn <= 16'h00ff;
    alt[0].outData <= 16'h00ff;
    idle(4);
    chk("alt and latch", pinOut[6], 16'h0003);
    chk("alt on input", pinOe[0], 16'h0000);
    alt[0].autoDir <= 16'h00ff;
    alt[0].autoOut <= 16'h00ff;
    idle(4);
    chk("hardware direction", pinOe[0], 16'h00ff);
    // open drain on port 2 with one line pulled low outside
    acc(4'h4, DAT, WR, 16'h003c, 16'h00ff);
    acc(4'h4, ODR, WR, 16'h00ff, 16'h00ff);
    acc(4'h4, DIR, WR, 16'h00ff, 16'h00ff);
    extEn[4] <= 16'h0004;
    idle(10);
    chk("drain level", pinOut[4], 16'h0000);
    chk("drain enable", pinOe[4], 16'h00c3);
    chk("wired and", altIn[4], 16'h0038);
    rdchk(4'h4, DAT, 16'h003c, "output read");
    // refused and narrow places
    acc(4'h6, ODR, WR, 16'hffff, 16'hffff);
    rdchk(4'h6, ODR, 16'h0000, "no drain select");
    acc(4'h5, ODR, WR, 16'hffff, 16'hffff);
    rdchk(4'h5, ODR, 16'h7fff, "port 3 width");
    acc(4'h7, DIR, WR, 16'h003f, 16'h003f);
    rdchk(4'h7, DIR, 16'h0000, "input only port");
    extEn[7] <= 16'h003f;
    extVal[7] <= 16'h0015;
    idle(10);
    rdchk(4'h7, DAT, 16'h0015, "input port read");
    rdchk(4'h9, DAT, 16'h0000, "no such port");
    // clock enable low freezes the pin path, high lets it catch up
    ce <= 1'b0;
    extVal[7] <= 16'h002a;
    idle(10);
    chk("frozen alt input", altIn[7], 16'h0015);
    ce <= 1'b1;
    idle(10);
    chk("thawed alt input", altIn[7], 16'h002a);
    // second reset in mid-run
    reset <= 1'b1;
    idle(5);
    reset <= 1'b0;
    idle(2);
    rdchk(4'h6, DIR, 16'h0000, "direction after reset");
    chk("floats after reset", pinOe[6], 16'h0000);
    report_and_stop();
  end
endmodule : testbench
